// >>> hw/lirr_route_regs.sv
// Purpose: Routing registers for the right line one input into both ADC mixers.
// Assumes: Register port is synchronous to core_clk; one access per cycle.
// Notes: Reads answer one cycle later; unmapped reads return zero.
//
// Functional notes
// - Bit 7 chooses single-ended (0) or fully differential (1); resets to 0.
// - Bits 6..3 set attenuation, codes 0..8 give 0 to -12 dB in 1.5 dB.
// - Any valid level code connects the input to that mixer by itself.
// - Level code 15 disconnects the input; the field resets to 15.
// - Left register bits 2..0 are read-only, reset 0, written as zeros.
// - Right register bit 2 powers the right ADC channel up; resets to 0.
// - Right bits 1..0: step each sample, each two samples, or disabled.
`timescale 1ns/1ns
`default_nettype none
module lirr_route_regs (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [lirr_pkg::LIRR_ADDR_W-1:0] reg_addr,
   input wire logic [lirr_pkg::LIRR_DATA_W-1:0] reg_wr_data,
   output logic [lirr_pkg::LIRR_DATA_W-1:0] reg_rd_data,
   output logic reg_rd_valid,
   output logic left_line_diff,
   output logic [lirr_pkg::LIRR_LEVEL_W-1:0] left_level_code,
   output logic left_line_connected,
   output logic [lirr_pkg::LIRR_ATTEN_W-1:0] left_atten_half_db,
   output logic right_line_diff,
   output logic [lirr_pkg::LIRR_LEVEL_W-1:0] right_level_code,
   output logic right_line_connected,
   output logic [lirr_pkg::LIRR_ATTEN_W-1:0] right_atten_half_db,
   output logic right_adc_power_up,
   output var lirr_pkg::lirr_step_type right_softstep
);
   import lirr_pkg::*;

   typedef struct packed {
      logic left_cfg;
      logic [LIRR_LEVEL_W-1:0] left_level;
      logic right_cfg;
      logic [LIRR_LEVEL_W-1:0] right_level;
      logic right_pwr;
      logic [1:0] right_step;
      lirr_step_type step_mode;
      logic [LIRR_DATA_W-1:0] rd_data;
      logic rd_valid;
   } lirr_state_type;

   lirr_state_type state;
   lirr_state_type next_state;
   logic left_sel;
   logic right_sel;

   assign left_sel = reg_addr == LIRR_LEFT_ROUTE_ADDR;
   assign right_sel = reg_addr == LIRR_RIGHT_ROUTE_ADDR;

   always_comb begin
      next_state = state;
      next_state.rd_valid = reg_rd_en;
      next_state.rd_data = LIRR_UNMAPPED_READ;
      if (reg_rd_en && left_sel) begin
         next_state.rd_data = {state.left_cfg, state.left_level,
            LIRR_LEFT_RESERVED_VALUE};
      end else if (reg_rd_en && right_sel) begin
         next_state.rd_data = {state.right_cfg, state.right_level,
            state.right_pwr, state.right_step};
      end
      if (reg_wr_en && left_sel) begin
         // Low bits of a left write are dropped, they are read-only.
         next_state.left_cfg = reg_wr_data[LIRR_CFG_BIT];
         next_state.left_level =
            reg_wr_data[LIRR_LEVEL_MSB:LIRR_LEVEL_LSB];
      end
      if (reg_wr_en && right_sel) begin
         next_state.right_cfg = reg_wr_data[LIRR_CFG_BIT];
         next_state.right_level =
            reg_wr_data[LIRR_LEVEL_MSB:LIRR_LEVEL_LSB];
         next_state.right_pwr = reg_wr_data[LIRR_PWR_BIT];
         next_state.right_step =
            reg_wr_data[LIRR_STEP_MSB:LIRR_STEP_LSB];
         next_state.step_mode = lirr_step_decode(
            reg_wr_data[LIRR_STEP_MSB:LIRR_STEP_LSB]);
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state.left_cfg <= LIRR_CFG_RESET;
         state.left_level <= LIRR_LEVEL_RESET;
         state.right_cfg <= LIRR_CFG_RESET;
         state.right_level <= LIRR_LEVEL_RESET;
         state.right_pwr <= LIRR_PWR_RESET;
         state.right_step <= LIRR_STEP_RESET;
         state.step_mode <= LIRR_STEP_EVERY_SAMPLE;
         state.rd_data <= LIRR_UNMAPPED_READ;
         state.rd_valid <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   // Level decode sits one register behind the stored field.
   lirr_level_decode u_left_decode (
      .core_clk(core_clk),
      .rst(rst),
      .level_code(state.left_level),
      .connected(left_line_connected),
      .atten_half_db(left_atten_half_db)
   );

   lirr_level_decode u_right_decode (
      .core_clk(core_clk),
      .rst(rst),
      .level_code(state.right_level),
      .connected(right_line_connected),
      .atten_half_db(right_atten_half_db)
   );

   assign reg_rd_data = state.rd_data;
   assign reg_rd_valid = state.rd_valid;
   assign left_line_diff = state.left_cfg;
   assign left_level_code = state.left_level;
   assign right_line_diff = state.right_cfg;
   assign right_level_code = state.right_level;
   assign right_adc_power_up = state.right_pwr;
   assign right_softstep = state.step_mode;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   property p_cfg_write;
      reg_wr_en && left_sel |=>
         left_line_diff == $past(reg_wr_data[LIRR_CFG_BIT]);
   endproperty
   a_cfg_write: assert property (p_cfg_write)
      else $error("Left configuration bit did not follow the write.");

   property p_level_write;
      reg_wr_en && right_sel |=>
         right_level_code ==
         $past(reg_wr_data[LIRR_LEVEL_MSB:LIRR_LEVEL_LSB]);
   endproperty
   a_level_write: assert property (p_level_write)
      else $error("Right level field did not follow the write.");

   property p_atten_value;
      lirr_level_valid(left_level_code) && $stable(left_level_code) |=>
         left_atten_half_db == ($past(left_level_code) * 5'h03);
   endproperty
   a_atten_value: assert property (p_atten_value)
      else $error("Left attenuation does not match the level code.");

   property p_connect;
      reg_wr_en && right_sel &&
         lirr_level_valid(reg_wr_data[LIRR_LEVEL_MSB:LIRR_LEVEL_LSB]) |=>
         ##1 right_line_connected;
   endproperty
   a_connect: assert property (p_connect)
      else $error("Valid level code did not connect the right input.");

   property p_disconnect;
      left_level_code == LIRR_LEVEL_DISCONNECT |=> !left_line_connected;
   endproperty
   a_disconnect: assert property (p_disconnect)
      else $error("Level code 15 left the input connected.");

   property p_reset_values;
      $past(rst) |-> left_level_code == LIRR_LEVEL_DISCONNECT &&
         right_level_code == LIRR_LEVEL_DISCONNECT &&
         !right_adc_power_up && !left_line_diff && !right_line_diff;
   endproperty
   a_reset_values: assert property (p_reset_values)
      else $error("Register fields not at reset values after reset.");

   property p_reserved_read;
      reg_rd_en && left_sel |=> reg_rd_valid && reg_rd_data[2:0] == 3'h0;
   endproperty
   a_reserved_read: assert property (p_reserved_read)
      else $error("Reserved left bits did not read as zero.");

   property p_power_write;
      reg_wr_en && right_sel |=>
         right_adc_power_up == $past(reg_wr_data[LIRR_PWR_BIT]);
   endproperty
   a_power_write: assert property (p_power_write)
      else $error("Right ADC power bit did not follow the write.");

   property p_step_mode;
      reg_wr_en && right_sel &&
         reg_wr_data[LIRR_STEP_MSB:LIRR_STEP_LSB] == LIRR_STEP_CODE_EVERY_TWO
         |=> right_softstep == LIRR_STEP_EVERY_TWO;
   endproperty
   a_step_mode: assert property (p_step_mode)
      else $error("Soft-step code 1 did not select every two samples.");

   property p_step_off;
      reg_wr_en && right_sel && reg_wr_data[1] |=>
         right_softstep == LIRR_STEP_DISABLED;
   endproperty
   a_step_off: assert property (p_step_off)
      else $error("Soft-step codes 2 and 3 did not disable stepping.");

   property p_right_readback;
      reg_rd_en && right_sel && !reg_wr_en |=>
         reg_rd_data[LIRR_CFG_BIT:LIRR_PWR_BIT] ==
         {right_line_diff, right_level_code, right_adc_power_up} &&
         lirr_step_decode(reg_rd_data[LIRR_STEP_MSB:LIRR_STEP_LSB]) ==
         right_softstep;
   endproperty
   a_right_readback: assert property (p_right_readback)
      else $error("Right register read back the wrong value.");

   c_left_connect: cover property (reg_wr_en && left_sel ##2
      left_line_connected);
   c_right_power: cover property (reg_wr_en && right_sel ##1
      right_adc_power_up);
   c_disconnect_again: cover property (right_line_connected ##[1:20]
      !right_line_connected);
   c_left_read: cover property (reg_rd_en && left_sel ##1 reg_rd_valid);

endmodule // lirr_route_regs
`default_nettype wire

// >>> hw/lirr_pkg.sv
// Purpose: Shared constants and types for the line input ADC routing registers.
// Assumes: Register numbers are the page 0 register indices of the device.
// Notes: Field positions, reset values and decode constants live here.
package lirr_pkg;

   localparam int LIRR_ADDR_W = 7;
   localparam int LIRR_DATA_W = 8;
   localparam int LIRR_LEVEL_W = 4;
   localparam int LIRR_ATTEN_W = 5;

   localparam logic [LIRR_ADDR_W-1:0] LIRR_LEFT_ROUTE_ADDR = 7'h15;
   localparam logic [LIRR_ADDR_W-1:0] LIRR_RIGHT_ROUTE_ADDR = 7'h16;

   localparam int LIRR_CFG_BIT = 7;
   localparam int LIRR_LEVEL_MSB = 6;
   localparam int LIRR_LEVEL_LSB = 3;
   localparam int LIRR_PWR_BIT = 2;
   localparam int LIRR_STEP_MSB = 1;
   localparam int LIRR_STEP_LSB = 0;

   localparam logic LIRR_CFG_RESET = 1'h0;
   localparam logic [LIRR_LEVEL_W-1:0] LIRR_LEVEL_RESET = 4'hF;
   localparam logic LIRR_PWR_RESET = 1'h0;
   localparam logic [1:0] LIRR_STEP_RESET = 2'h0;
   localparam logic [2:0] LIRR_LEFT_RESERVED_VALUE = 3'h0;

   localparam logic [LIRR_LEVEL_W-1:0] LIRR_LEVEL_MAX_VALID = 4'h8;
   localparam logic [LIRR_LEVEL_W-1:0] LIRR_LEVEL_DISCONNECT = 4'hF;
   localparam logic [1:0] LIRR_STEP_CODE_EVERY_SAMPLE = 2'h0;
   localparam logic [1:0] LIRR_STEP_CODE_EVERY_TWO = 2'h1;
   localparam logic [LIRR_DATA_W-1:0] LIRR_UNMAPPED_READ = 8'h00;

   typedef enum logic [1:0] {
      LIRR_STEP_EVERY_SAMPLE,
      LIRR_STEP_EVERY_TWO,
      LIRR_STEP_DISABLED
   } lirr_step_type;

   // Attenuation code in the range that connects the input to the mixer.
   function automatic logic lirr_level_valid(
      input logic [LIRR_LEVEL_W-1:0] code);
      return code <= LIRR_LEVEL_MAX_VALID;
   endfunction

   // Maps the raw soft-step field onto the stepping mode.
   function automatic lirr_step_type lirr_step_decode(input logic [1:0] code);
      if (code == LIRR_STEP_CODE_EVERY_SAMPLE) begin
         return LIRR_STEP_EVERY_SAMPLE;
      end else if (code == LIRR_STEP_CODE_EVERY_TWO) begin
         return LIRR_STEP_EVERY_TWO;
      end else begin
         return LIRR_STEP_DISABLED;
      end
   endfunction

endpackage

// >>> hw/lirr_level_decode.sv
// Purpose: Registered decode of one level field into connect and attenuation.
// Assumes: Level code is a stored register field, stable between writes.
// Notes: Attenuation is given in units of 0.5 dB; invalid codes disconnect.
`timescale 1ns/1ns
`default_nettype none
module lirr_level_decode (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [lirr_pkg::LIRR_LEVEL_W-1:0] level_code,
   output logic connected,
   output logic [lirr_pkg::LIRR_ATTEN_W-1:0] atten_half_db
);
   import lirr_pkg::*;

   typedef struct packed {
      logic connected;
      logic [LIRR_ATTEN_W-1:0] atten;
   } lirr_dec_state_type;

   lirr_dec_state_type state;
   lirr_dec_state_type next_state;

   always_comb begin
      next_state.connected = lirr_level_valid(level_code);
      next_state.atten = 5'h00;
      if (lirr_level_valid(level_code)) begin
         // Each code step is 1.5 dB, that is three half-dB units.
         next_state.atten = LIRR_ATTEN_W'(level_code)
            + LIRR_ATTEN_W'({level_code, 1'b0});
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign connected = state.connected;
   assign atten_half_db = state.atten;

endmodule // lirr_level_decode
`default_nettype wire

// >>> test/lirr_route_regs_tb.sv
// Purpose: Self-checking bench for the line input routing registers.
// Assumes: Reads answer one cycle after the strobe; inputs change at negedge.
// Notes: Shadow copies of both registers predict every mapped readback and every output.
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import lirr_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic reg_wr_en = 1'b0;
   logic reg_rd_en = 1'b0;
   logic [LIRR_ADDR_W-1:0] reg_addr = 7'h00;
   logic [LIRR_DATA_W-1:0] reg_wr_data = 8'h00;
   logic [LIRR_DATA_W-1:0] reg_rd_data;
   logic reg_rd_valid, left_line_diff, left_line_connected;
   logic right_line_diff, right_line_connected, right_adc_power_up;
   logic [LIRR_LEVEL_W-1:0] left_level_code, right_level_code;
   logic [LIRR_ATTEN_W-1:0] left_atten_half_db, right_atten_half_db;
   lirr_step_type right_softstep;
   logic [7:0] shadow_left = 8'h78;
   logic [7:0] shadow_right = 8'h78;
   int errors = 0;
   int check_count = 0;

   lirr_route_regs lirr_route_regs_i (
      .core_clk(core_clk),
      .rst(rst),
      .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en),
      .reg_addr(reg_addr),
      .reg_wr_data(reg_wr_data),
      .reg_rd_data(reg_rd_data),
      .reg_rd_valid(reg_rd_valid),
      .left_line_diff(left_line_diff),
      .left_level_code(left_level_code),
      .left_line_connected(left_line_connected),
      .left_atten_half_db(left_atten_half_db),
      .right_line_diff(right_line_diff),
      .right_level_code(right_level_code),
      .right_line_connected(right_line_connected),
      .right_atten_half_db(right_atten_half_db),
      .right_adc_power_up(right_adc_power_up),
      .right_softstep(right_softstep)
   );

   always #50 core_clk = ~core_clk;

   // Valid codes connect; anything above eight leaves the input unrouted.
   function automatic logic [7:0] exp_conn(input logic [3:0] code);
      return (code <= 4'h8) ? 8'h01 : 8'h00;
   endfunction

   // Half-dB units, three per code step.
   function automatic logic [7:0] exp_atten(input logic [3:0] code);
      return (code <= 4'h8) ? {4'h0, code} * 8'h03 : 8'h00;
   endfunction

   function automatic lirr_step_type exp_step(input logic [1:0] code);
      if (code == 2'h0) begin
         return LIRR_STEP_EVERY_SAMPLE;
      end
      if (code == 2'h1) begin
         return LIRR_STEP_EVERY_TWO;
      end
      return LIRR_STEP_DISABLED;
   endfunction

   task automatic check_val(input logic [7:0] got, input logic [7:0] exp,
                            input string what);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what,
                  got, exp);
      end
   endtask

   task automatic write_reg(input logic [6:0] addr, input logic [7:0] data);
      @(negedge core_clk);
      reg_wr_en = 1'b1;
      reg_addr = addr;
      reg_wr_data = data;
      @(negedge core_clk);
      reg_wr_en = 1'b0;
      if (addr == LIRR_LEFT_ROUTE_ADDR) begin
         shadow_left = data & 8'hF8;
      end
      if (addr == LIRR_RIGHT_ROUTE_ADDR) begin
         shadow_right = data;
      end
   endtask

   task automatic read_check(input logic [6:0] addr, input logic [7:0] exp);
      @(negedge core_clk);
      reg_rd_en = 1'b1;
      reg_addr = addr;
      @(negedge core_clk);
      reg_rd_en = 1'b0;
      check_val(8'(reg_rd_valid), 8'h01, "read valid");
      check_val(reg_rd_data, exp, "read data");
   endtask

   task automatic check_outs;
      @(negedge core_clk);
      check_val(8'(left_line_diff), 8'(shadow_left[7]), "left diff");
      check_val(8'(left_level_code), 8'(shadow_left[6:3]), "l lvl");
      check_val(8'(left_line_connected), exp_conn(shadow_left[6:3]),
                "left connect");
      check_val(8'(left_atten_half_db), exp_atten(shadow_left[6:3]),
                "left atten");
      check_val(8'(right_line_diff), 8'(shadow_right[7]), "r diff");
      check_val(8'(right_level_code), 8'(shadow_right[6:3]), "r lvl");
      check_val(8'(right_line_connected), exp_conn(shadow_right[6:3]),
                "right connect");
      check_val(8'(right_atten_half_db), exp_atten(shadow_right[6:3]),
                "right atten");
      check_val(8'(right_adc_power_up), 8'(shadow_right[2]), "pwr");
      check_val(8'(right_softstep), 8'(exp_step(shadow_right[1:0])),
                "soft step");
      read_check(LIRR_LEFT_ROUTE_ADDR, shadow_left);
      read_check(LIRR_RIGHT_ROUTE_ADDR, shadow_right);
   endtask

   task automatic print_verdict;
      $display("Checks: %0d, errors: %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Stops a hung run well past the expected length of about 410 cycles.
   initial begin
      #400000;
      errors++;
      print_verdict;
   end

   initial begin
      logic [3:0] lvl;
      logic diff;
      void'($urandom(63));
      repeat (3) @(negedge core_clk);
      rst = 1'b0;
      check_outs;
      write_reg(7'h14, 8'hFF);
      read_check(7'h17, 8'h00);
      write_reg(LIRR_LEFT_ROUTE_ADDR, 8'hC7);
      check_outs;
      for (int s = 0; s < 4; s++) begin
         write_reg(LIRR_RIGHT_ROUTE_ADDR, 8'h04 | 8'(s));
         check_outs;
      end
      for (int i = 0; i < 40; i++) begin
         diff = 1'($urandom_range(0, 1));
         lvl = 4'($urandom_range(0, 9));
         lvl = (lvl == 4'h9) ? LIRR_LEVEL_DISCONNECT : lvl;
         write_reg(LIRR_LEFT_ROUTE_ADDR,
                   {diff, lvl, LIRR_LEFT_RESERVED_VALUE});
         lvl = 4'($urandom_range(0, 9));
         lvl = (lvl == 4'h9) ? LIRR_LEVEL_DISCONNECT : lvl;
         write_reg(LIRR_RIGHT_ROUTE_ADDR, {diff, lvl, 3'($urandom)});
         check_outs;
      end
      @(negedge core_clk);
      rst = 1'b1;
      @(negedge core_clk);
      rst = 1'b0;
      shadow_left = 8'h78;
      shadow_right = 8'h78;
      check_outs;
      print_verdict;
   end
endmodule // testbench
`default_nettype wire
